// ### rtl/sdsm_pkg.sv
// package: register map, command and state encodings for the drive state machine
package sdsm_pkg;

  // ---------------------------------------------------------------
  // register indices, not byte offsets (byte address is index * 4)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_COUNTER_SETUP     = 8'h20;
  localparam logic [7:0] IDX_HOLDING_CURRENT   = 8'h21;
  localparam logic [7:0] IDX_NOMINAL_CURRENT   = 8'h22;
  localparam logic [7:0] IDX_MAXIMUM_CURRENT   = 8'h23;
  localparam logic [7:0] IDX_STALL_THRESHOLD   = 8'h2C;
  localparam logic [7:0] IDX_MODULE_SETUP      = 8'h2E;
  localparam logic [7:0] IDX_MIXED_DECAY       = 8'h34;
  localparam logic [7:0] IDX_FULL_STEP_THRESH  = 8'h54;
  localparam logic [7:0] IDX_STALL_MIN_SPEED   = 8'h5C;
  localparam logic [7:0] IDX_CONTROL_WORD      = 8'h60;
  localparam logic [7:0] IDX_STATUS_WORD       = 8'h61;
  localparam logic [7:0] IDX_ERROR_CODE        = 8'h62;
  localparam int         ADDR_W                = 10;

  // ---------------------------------------------------------------
  // control word command codes (low 3 bits)
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_NONE         = 3'h0;
  localparam logic [2:0] CMD_SHUTDOWN     = 3'h1;
  localparam logic [2:0] CMD_SWITCH_ON    = 3'h2;
  localparam logic [2:0] CMD_ENABLE_OP    = 3'h3;
  localparam logic [2:0] CMD_DISABLE_OP   = 3'h4;
  localparam logic [2:0] CMD_DISABLE_VOLT = 3'h5;
  localparam logic [2:0] CMD_QUICK_STOP   = 3'h6;
  localparam logic [2:0] CMD_FAULT_RESET  = 3'h7;

  // ---------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------
  localparam int STS_STATE_LSB = 0;
  localparam int STS_VOLTAGE   = 4;
  localparam int STS_WARNING   = 5;
  localparam int STS_FAULT     = 6;

  // ---------------------------------------------------------------
  // error sources; lower index = higher priority
  // ---------------------------------------------------------------
  localparam int NUM_ERR = 4;
  localparam logic [15:0] WARNING_CODE = 16'h0001;
  localparam logic [15:0] ERR_CODE_BASE = 16'h1000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0]
  {
    SDSM_SW_DISABLED   = 3'b000,
    SDSM_READY         = 3'b001,
    SDSM_SWITCHED_ON   = 3'b011,
    SDSM_OP_ENABLED    = 3'b010,
    SDSM_QUICK_STOP    = 3'b110,
    SDSM_FAULT_REACT   = 3'b111,
    SDSM_FAULT         = 3'b101
  } sdsm_state_e;

endpackage : sdsm_pkg

// ### rtl/sdsm_stepper_drive.sv
// drive state machine of a stepper motor module with AXI4-Lite registers
// How it works
// - Shutdown in operation-enabled goes to ready-to-switch-on, voltage off now.
// - Disable-voltage in operation-enabled goes to switch-on-disabled, voltage off.
// - Quick stop in operation-enabled enters quick-stop-active and brakes.
// - Standstill during quick-stop-active moves to switch-on-disabled by itself.
// - Enable-operation in quick-stop-active returns to operation-enabled.
// - Only an error event enters fault-reaction-active, never a command.
// - A warning event sets the warning bit and, with no stored error, the warning code; state stays.
// - Fault-reaction-active removes voltage and passes at once to fault.
// - The error code shows the single highest-priority stored error.
// - Fault reset leaves fault only if no error is pending when written.
// - A fault reset that leaves fault clears stored errors and warnings; a live warning shows.
//
// Chosen here: register access over AXI4-Lite.
module sdsm_stepper_drive
  import sdsm_pkg::*;
#(
  parameter int NUM_ERRORS = NUM_ERR
)
(
  // clock and reset
  input  wire logic                  CLK_SYS,
  input  wire logic                  RSTN,
  // axi4-lite write address / data / response
  input  wire logic [ADDR_W-1:0]     S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  // axi4-lite read address / data
  input  wire logic [ADDR_W-1:0]     S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  // motion and event inputs (asynchronous)
  input  wire logic                  MOTOR_STANDSTILL,
  input  wire logic [NUM_ERRORS-1:0] ERROR_EVENT,
  input  wire logic                  WARNING_EVENT,
  // drive outputs
  output logic                       MOTOR_VOLTAGE_ON,
  output logic                       BRAKE_DECEL,
  output logic                       MOTION_ENABLE,
  // configuration outputs
  output logic [7:0]                 COUNTER_SETUP,
  output logic [7:0]                 HOLDING_CURRENT,
  output logic [7:0]                 NOMINAL_CURRENT,
  output logic [7:0]                 MAXIMUM_CURRENT,
  output logic [15:0]                STALL_THRESHOLD,
  output logic [15:0]                MODULE_SETUP,
  output logic [15:0]                MIXED_DECAY_THRESHOLD,
  output logic [15:0]                FULL_STEP_THRESHOLD,
  output logic [15:0]                STALL_MIN_SPEED
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SYN_W = NUM_ERRORS + 2;
  logic [SYN_W-1:0] sync1_reg;
  logic [SYN_W-1:0] sync2_reg;

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {MOTOR_STANDSTILL, WARNING_EVENT, ERROR_EVENT};
      sync2_reg <= sync1_reg;
    end
  end

  logic [NUM_ERRORS-1:0] err_live;
  logic                  warn_live;
  logic                  standstill;
  assign err_live   = sync2_reg[NUM_ERRORS-1:0];
  assign warn_live  = sync2_reg[NUM_ERRORS];
  assign standstill = sync2_reg[NUM_ERRORS+1];

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              wr_fire;
  logic [7:0]        wr_idx;
  logic              wr_hit;

  assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign S_AXI_WREADY  = !w_full_reg && !bvalid_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign wr_fire       = aw_full_reg && w_full_reg && !bvalid_reg;
  // offsets are register indices; byte address is index times four
  assign wr_idx        = 8'(awaddr_reg[ADDR_W-1:2]);

  always_comb
  begin
    case (wr_idx)
      IDX_COUNTER_SETUP, IDX_HOLDING_CURRENT, IDX_NOMINAL_CURRENT,
      IDX_MAXIMUM_CURRENT, IDX_STALL_THRESHOLD, IDX_MODULE_SETUP,
      IDX_MIXED_DECAY, IDX_FULL_STEP_THRESH, IDX_STALL_MIN_SPEED,
      IDX_CONTROL_WORD: wr_hit = 1'b1;
      default:          wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_full_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && S_AXI_BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write-only configuration registers
  // ---------------------------------------------------------------
  logic [15:0] wmask16;
  logic [15:0] wval16;
  assign wmask16 = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  function automatic logic [15:0] merge16(input logic [15:0] old);
    merge16 = (old & ~wmask16) | (wdata_reg[15:0] & wmask16);
  endfunction : merge16

  assign wval16 = wdata_reg[15:0];

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      COUNTER_SETUP         <= '0;
      HOLDING_CURRENT       <= '0;
      NOMINAL_CURRENT       <= '0;
      MAXIMUM_CURRENT       <= '0;
      STALL_THRESHOLD       <= '0;
      MODULE_SETUP          <= '0;
      MIXED_DECAY_THRESHOLD <= '0;
      FULL_STEP_THRESHOLD   <= '0;
      STALL_MIN_SPEED       <= '0;
    end
    else if (wr_fire && wstrb_reg[0])
    begin
      case (wr_idx)
        IDX_COUNTER_SETUP:    COUNTER_SETUP   <= wval16[7:0];
        IDX_HOLDING_CURRENT:  HOLDING_CURRENT <= wval16[7:0];
        IDX_NOMINAL_CURRENT:  NOMINAL_CURRENT <= wval16[7:0];
        IDX_MAXIMUM_CURRENT:  MAXIMUM_CURRENT <= wval16[7:0];
        IDX_STALL_THRESHOLD:  STALL_THRESHOLD <= merge16(STALL_THRESHOLD);
        IDX_MODULE_SETUP:     MODULE_SETUP    <= merge16(MODULE_SETUP);
        IDX_MIXED_DECAY:
          MIXED_DECAY_THRESHOLD <= merge16(MIXED_DECAY_THRESHOLD);
        IDX_FULL_STEP_THRESH:
          FULL_STEP_THRESHOLD <= merge16(FULL_STEP_THRESHOLD);
        IDX_STALL_MIN_SPEED:  STALL_MIN_SPEED <= merge16(STALL_MIN_SPEED);
        default:              ;
      endcase
    end
  end

  // a command is a one-cycle pulse taken from a control word write
  logic       cmd_valid;
  logic [2:0] cmd;
  assign cmd_valid = wr_fire && wstrb_reg[0] && (wr_idx == IDX_CONTROL_WORD);
  assign cmd       = cmd_valid ? wdata_reg[2:0] : CMD_NONE;

  // ---------------------------------------------------------------
  // error and warning store
  // ---------------------------------------------------------------
  sdsm_state_e           state_reg;
  logic [NUM_ERRORS-1:0] err_store_reg;
  logic                  warn_store_reg;
  logic                  reset_ok;

  // only live error inputs block a fault reset: stored ones are what
  // brought the machine to fault and the reset clears them itself
  assign reset_ok = (cmd == CMD_FAULT_RESET) && (state_reg == SDSM_FAULT)
                 && (err_live == '0);

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      err_store_reg  <= '0;
      warn_store_reg <= 1'b0;
    end
    else
    begin
      // new events win over the clear done by a fault reset
      err_store_reg  <= (reset_ok ? '0 : err_store_reg) | err_live;
      warn_store_reg <= (reset_ok ? 1'b0 : warn_store_reg) | warn_live;
    end
  end

  // fixed priority: lowest error index wins
  logic [15:0] error_code;
  always_comb
  begin
    error_code = warn_store_reg ? WARNING_CODE : 16'h0000;
    for (int i = NUM_ERRORS - 1; i >= 0; i--)
    begin
      if (err_store_reg[i])
        error_code = ERR_CODE_BASE + 16'(i);
    end
  end

  // ---------------------------------------------------------------
  // drive state machine
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      state_reg <= SDSM_SW_DISABLED;
    else if (err_live != '0 && state_reg != SDSM_FAULT_REACT
             && state_reg != SDSM_FAULT)
      state_reg <= SDSM_FAULT_REACT;
    else
    begin
      case (state_reg)
        SDSM_SW_DISABLED:
          if (cmd == CMD_SHUTDOWN)
            state_reg <= SDSM_READY;
        SDSM_READY:
          if (cmd == CMD_SWITCH_ON)
            state_reg <= SDSM_SWITCHED_ON;
          else if (cmd == CMD_DISABLE_VOLT || cmd == CMD_QUICK_STOP)
            state_reg <= SDSM_SW_DISABLED;
        SDSM_SWITCHED_ON:
          if (cmd == CMD_ENABLE_OP)
            state_reg <= SDSM_OP_ENABLED;
          else if (cmd == CMD_SHUTDOWN)
            state_reg <= SDSM_READY;
          else if (cmd == CMD_DISABLE_VOLT || cmd == CMD_QUICK_STOP)
            state_reg <= SDSM_SW_DISABLED;
        SDSM_OP_ENABLED:
          if (cmd == CMD_SHUTDOWN)
            state_reg <= SDSM_READY;
          else if (cmd == CMD_DISABLE_VOLT)
            state_reg <= SDSM_SW_DISABLED;
          else if (cmd == CMD_QUICK_STOP)
            state_reg <= SDSM_QUICK_STOP;
          else if (cmd == CMD_DISABLE_OP)
            state_reg <= SDSM_SWITCHED_ON;
        SDSM_QUICK_STOP:
          if (cmd == CMD_ENABLE_OP)
            state_reg <= SDSM_OP_ENABLED;
          else if (standstill)
            state_reg <= SDSM_SW_DISABLED;
        SDSM_FAULT_REACT:
          state_reg <= SDSM_FAULT;
        SDSM_FAULT:
          if (reset_ok)
            state_reg <= SDSM_SW_DISABLED;
        default:
          state_reg <= SDSM_SW_DISABLED;
      endcase
    end
  end

  // voltage is on only in states that hold the coils powered
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      MOTOR_VOLTAGE_ON <= 1'b0;
      BRAKE_DECEL      <= 1'b0;
      MOTION_ENABLE    <= 1'b0;
    end
    else
    begin
      MOTOR_VOLTAGE_ON <= 1'b0;
      BRAKE_DECEL      <= 1'b0;
      MOTION_ENABLE    <= 1'b0;
      case (state_reg)
        SDSM_SWITCHED_ON: MOTOR_VOLTAGE_ON <= 1'b1;
        SDSM_OP_ENABLED:
        begin
          MOTOR_VOLTAGE_ON <= 1'b1;
          MOTION_ENABLE    <= 1'b1;
        end
        SDSM_QUICK_STOP:
        begin
          MOTOR_VOLTAGE_ON <= 1'b1;
          BRAKE_DECEL      <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  logic [7:0]  rd_idx;
  logic [31:0] status_word;
  assign rd_idx = 8'(S_AXI_ARADDR[ADDR_W-1:2]);

  always_comb
  begin
    status_word = '0;
    status_word[STS_STATE_LSB +: 3] = state_reg;
    status_word[STS_VOLTAGE]        = MOTOR_VOLTAGE_ON;
    status_word[STS_WARNING]        = warn_store_reg;
    status_word[STS_FAULT]          = (state_reg == SDSM_FAULT);
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= RESP_OKAY;
      case (rd_idx)
        IDX_STATUS_WORD: S_AXI_RDATA <= status_word;
        IDX_ERROR_CODE:  S_AXI_RDATA <= {16'h0000, error_code};
        default:
        begin
          // configuration registers are write-only and read as zero
          S_AXI_RDATA <= '0;
          S_AXI_RRESP <= RESP_SLVERR;
        end
      endcase
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

endmodule : sdsm_stepper_drive

// ### test/sdsm_stepper_drive_properties.sv
// checker: drive state machine and register bus properties
module sdsm_stepper_drive_properties
  import sdsm_pkg::*;
#(
  parameter int NUM_ERRORS = NUM_ERR
)
(
  // clock and reset
  input wire logic                  CLK_SYS,
  input wire logic                  RSTN,
  // register bus
  input wire logic [ADDR_W-1:0]     S_AXI_AWADDR,
  input wire logic                  S_AXI_AWVALID,
  input wire logic                  S_AXI_AWREADY,
  input wire logic [31:0]           S_AXI_WDATA,
  input wire logic                  S_AXI_WVALID,
  input wire logic                  S_AXI_WREADY,
  input wire logic                  S_AXI_BVALID,
  // drive
  input wire logic                  MOTOR_STANDSTILL,
  input wire logic [NUM_ERRORS-1:0] ERROR_EVENT,
  input wire logic                  MOTOR_VOLTAGE_ON,
  input wire logic                  BRAKE_DECEL,
  input wire logic                  MOTION_ENABLE
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  logic       wr_both;
  logic       cmd_go;
  logic [2:0] cmd;

  assign wr_both = S_AXI_AWVALID && S_AXI_AWREADY
                   && S_AXI_WVALID && S_AXI_WREADY;
  assign cmd_go  = wr_both && (S_AXI_AWADDR[9:2] == IDX_CONTROL_WORD);
  assign cmd     = S_AXI_WDATA[2:0];

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_shutdown;
    cmd_go && cmd == CMD_SHUTDOWN && MOTION_ENABLE
      |-> ##[1:3] (!MOTOR_VOLTAGE_ON && !MOTION_ENABLE);
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown kept voltage");

  property p_disvolt;
    cmd_go && cmd == CMD_DISABLE_VOLT && MOTION_ENABLE
      |-> ##[1:3] (!MOTOR_VOLTAGE_ON && !MOTION_ENABLE);
  endproperty
  a_disvolt: assert property (p_disvolt)
    else $error("disable voltage kept voltage");

  property p_qstop;
    cmd_go && cmd == CMD_QUICK_STOP && MOTION_ENABLE && !MOTOR_STANDSTILL
      |-> ##[1:3] (BRAKE_DECEL && MOTOR_VOLTAGE_ON);
  endproperty
  a_qstop: assert property (p_qstop)
    else $error("quick stop did not brake");

  // six cycles cover the input sync plus a command still settling
  property p_qs_exit;
    (MOTOR_STANDSTILL && !S_AXI_AWVALID) [*6] |-> !BRAKE_DECEL;
  endproperty
  a_qs_exit: assert property (p_qs_exit)
    else $error("braking at standstill");

  property p_qs_enable;
    cmd_go && cmd == CMD_ENABLE_OP && BRAKE_DECEL && !MOTOR_STANDSTILL
      |-> ##[1:3] (MOTION_ENABLE && !BRAKE_DECEL);
  endproperty
  a_qs_enable: assert property (p_qs_enable)
    else $error("enable from quick stop failed");

  property p_fault_off;
    (ERROR_EVENT != '0) [*6]
      |-> !MOTOR_VOLTAGE_ON && !MOTION_ENABLE && !BRAKE_DECEL;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("voltage on with live error");

  property p_motion_volt;
    MOTION_ENABLE |-> MOTOR_VOLTAGE_ON;
  endproperty
  a_motion_volt: assert property (p_motion_volt)
    else $error("motion without voltage");

  // address and data are held one cycle, the response is raised the next
  property p_bvalid;
    wr_both |-> ##2 S_AXI_BVALID;
  endproperty
  a_bvalid: assert property (p_bvalid)
    else $error("write response late");

  c_brake: cover property (BRAKE_DECEL);
  c_fault: cover property (ERROR_EVENT != '0 && !MOTOR_VOLTAGE_ON);
  c_cmd:   cover property (cmd_go);
endmodule : sdsm_stepper_drive_properties

bind sdsm_stepper_drive sdsm_stepper_drive_properties
  #(.NUM_ERRORS(NUM_ERRORS)) u_props (.*);

// ### test/sdsm_plc_model.sv
// controller model: register bus master for commands and setup
module sdsm_plc_model
  import sdsm_pkg::*;
(
  // clock
  input  wire logic         CLK_SYS,
  // register bus, master side
  output logic [ADDR_W-1:0] S_AXI_AWADDR,
  output logic              S_AXI_AWVALID,
  input  wire logic         S_AXI_AWREADY,
  output logic [31:0]       S_AXI_WDATA,
  output logic [3:0]        S_AXI_WSTRB,
  output logic              S_AXI_WVALID,
  input  wire logic         S_AXI_WREADY,
  input  wire logic [1:0]   S_AXI_BRESP,
  input  wire logic         S_AXI_BVALID,
  output logic              S_AXI_BREADY,
  output logic [ADDR_W-1:0] S_AXI_ARADDR,
  output logic              S_AXI_ARVALID,
  input  wire logic         S_AXI_ARREADY,
  input  wire logic [31:0]  S_AXI_RDATA,
  input  wire logic [1:0]   S_AXI_RRESP,
  input  wire logic         S_AXI_RVALID,
  output logic              S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    S_AXI_AWADDR  = '0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WDATA   = '0;
    S_AXI_WSTRB   = 4'h0;
    S_AXI_WVALID  = 1'b0;
    S_AXI_BREADY  = 1'b0;
    S_AXI_ARADDR  = '0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY  = 1'b0;
  end

  // released payloads are inverted so no stale value looks valid
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    output logic [1:0] resp);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    S_AXI_AWADDR  <= {idx, 2'b00};
    S_AXI_WDATA   <= d;
    S_AXI_WSTRB   <= 4'hF;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    while (a || w)
    begin
      @(posedge CLK_SYS);
      if (a && S_AXI_AWREADY)
      begin
        a = 1'b0;
        S_AXI_AWVALID <= 1'b0;
        S_AXI_AWADDR  <= ~S_AXI_AWADDR;
      end
      if (w && S_AXI_WREADY)
      begin
        w = 1'b0;
        S_AXI_WVALID <= 1'b0;
        S_AXI_WDATA  <= ~S_AXI_WDATA;
      end
    end
    do
      @(posedge CLK_SYS);
    while (!S_AXI_BVALID);
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK_SYS);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    S_AXI_ARADDR  <= {idx, 2'b00};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do
      @(posedge CLK_SYS);
    while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    S_AXI_ARADDR  <= ~S_AXI_ARADDR;
    do
      @(posedge CLK_SYS);
    while (!S_AXI_RVALID);
    d    = S_AXI_RDATA;
    resp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK_SYS);
  endtask : rd
endmodule : sdsm_plc_model

// ### test/sdsm_stepper_drive_test.sv
// testbench: drive state machine, commands, faults and setup registers
module sdsm_stepper_drive_test
  import sdsm_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic              CLK_SYS, RSTN;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]       S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]        S_AXI_WSTRB, ERROR_EVENT;
  logic [1:0]        S_AXI_BRESP, S_AXI_RRESP;
  logic              S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic              S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic              S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic              S_AXI_RREADY, MOTOR_STANDSTILL, WARNING_EVENT;
  logic              MOTOR_VOLTAGE_ON, BRAKE_DECEL, MOTION_ENABLE;
  logic [7:0]        COUNTER_SETUP, HOLDING_CURRENT;
  logic [7:0]        NOMINAL_CURRENT, MAXIMUM_CURRENT;
  logic [15:0]       STALL_THRESHOLD, MODULE_SETUP, MIXED_DECAY_THRESHOLD;
  logic [15:0]       FULL_STEP_THRESHOLD, STALL_MIN_SPEED;
  int                fail_count;
  int                total_checks;

  // expected status word: state, voltage, warning, fault
  localparam logic [31:0] S_OFF  = 32'h00;
  localparam logic [31:0] S_RDY  = 32'h01;
  localparam logic [31:0] S_SWON = 32'h13;
  localparam logic [31:0] S_OP   = 32'h12;
  localparam logic [31:0] S_QS   = 32'h16;
  localparam logic [31:0] S_FLT  = 32'h45;
  localparam logic [31:0] S_WRN  = 32'h20;

  sdsm_stepper_drive #(.NUM_ERRORS(4)) dut (.*);
  sdsm_plc_model u_plc (.*);

  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] m, e,
                       input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    u_plc.rd(idx, d, r);
    chk(d & m, e);
    chk(32'(r), 32'(er));
  endtask : rdchk

  task automatic cmd(input logic [2:0] c);
    logic [1:0] r;
    u_plc.wr(IDX_CONTROL_WORD, {29'h0, c}, r);
    repeat (4) @(posedge CLK_SYS);
  endtask : cmd

  // events pass a two-stage sync, so let them settle
  task automatic ev(input logic [3:0] e, input logic w, s);
    ERROR_EVENT      <= e;
    WARNING_EVENT    <= w;
    MOTOR_STANDSTILL <= s;
    repeat (8) @(posedge CLK_SYS);
  endtask : ev

  task automatic go_op;
    cmd(CMD_SHUTDOWN);
    cmd(CMD_SWITCH_ON);
    cmd(CMD_ENABLE_OP);
  endtask : go_op

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] idx [9];
    logic [1:0] r;
    idx = '{IDX_COUNTER_SETUP, IDX_HOLDING_CURRENT, IDX_NOMINAL_CURRENT,
            IDX_MAXIMUM_CURRENT, IDX_STALL_THRESHOLD, IDX_MODULE_SETUP,
            IDX_MIXED_DECAY, IDX_FULL_STEP_THRESH, IDX_STALL_MIN_SPEED};
    for (int i = 0; i < 9; i++)
    begin
      u_plc.wr(idx[i], 32'h3C5A_96A0 + i, r);
      chk(32'(r), 32'(RESP_OKAY));
      rdchk(idx[i], 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
    end
    chk({COUNTER_SETUP, HOLDING_CURRENT, NOMINAL_CURRENT, MAXIMUM_CURRENT},
        32'hA0A1_A2A3);
    chk({STALL_THRESHOLD, MODULE_SETUP}, 32'h96A4_96A5);
    chk({MIXED_DECAY_THRESHOLD, FULL_STEP_THRESHOLD}, 32'h96A6_96A7);
    chk({16'h0, STALL_MIN_SPEED}, 32'h0000_96A8);
    u_plc.wr(8'h30, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rdchk(8'h30, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
  endtask : t_regs

  task automatic t_cmds;
    logic [31:0] e [7];
    e = '{S_RDY, S_SWON, S_OP, S_SWON, S_OFF, S_OFF, S_OFF};
    for (int c = 1; c < 8; c++)
    begin
      cmd(3'(c));
      rdchk(IDX_STATUS_WORD, 32'h7F, e[c-1], RESP_OKAY);
    end
  endtask : t_cmds

  task automatic t_drive;
    go_op();
    cmd(CMD_SHUTDOWN);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_RDY, RESP_OKAY);
    chk(32'(MOTOR_VOLTAGE_ON), 32'h0);
    go_op();
    ev(4'h0, 1'b0, 1'b1);
    cmd(CMD_DISABLE_VOLT);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_OFF, RESP_OKAY);
    chk(32'(MOTOR_VOLTAGE_ON), 32'h0);
  endtask : t_drive

  task automatic t_qstop;
    ev(4'h0, 1'b0, 1'b0);
    go_op();
    cmd(CMD_QUICK_STOP);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_QS, RESP_OKAY);
    chk(32'(BRAKE_DECEL), 32'h1);
    cmd(CMD_ENABLE_OP);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_OP, RESP_OKAY);
    chk(32'(MOTION_ENABLE), 32'h1);
    cmd(CMD_QUICK_STOP);
    ev(4'h0, 1'b0, 1'b1);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_OFF, RESP_OKAY);
  endtask : t_qstop

  task automatic t_fault;
    go_op();
    ev(4'h0, 1'b1, 1'b1);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_OP | S_WRN, RESP_OKAY);
    rdchk(IDX_ERROR_CODE, 32'hFFFF, 32'(WARNING_CODE), RESP_OKAY);
    ev(4'b0110, 1'b1, 1'b1);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_FLT | S_WRN, RESP_OKAY);
    chk(32'(MOTOR_VOLTAGE_ON), 32'h0);
    rdchk(IDX_ERROR_CODE, 32'hFFFF, 32'(ERR_CODE_BASE) + 1, RESP_OKAY);
    cmd(CMD_FAULT_RESET);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_FLT | S_WRN, RESP_OKAY);
    ev(4'h0, 1'b1, 1'b1);
    cmd(CMD_FAULT_RESET);
    rdchk(IDX_STATUS_WORD, 32'h7F, S_OFF | S_WRN, RESP_OKAY);
    rdchk(IDX_ERROR_CODE, 32'hFFFF, 32'(WARNING_CODE), RESP_OKAY);
  endtask : t_fault

  initial
  begin
    RSTN             = 1'b0;
    MOTOR_STANDSTILL = 1'b1;
    ERROR_EVENT      = 4'h0;
    WARNING_EVENT    = 1'b0;
    fail_count       = 0;
    total_checks     = 0;
    repeat (16) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    @(posedge CLK_SYS);
    chk(32'(MOTOR_VOLTAGE_ON), 32'h0);
    t_regs();
    t_cmds();
    t_drive();
    t_qstop();
    t_fault();
    stop_test();
  end

  // whole run is a few hundred cycles; this is far beyond it
  initial
  begin
    #80000;
    fail_count++;
    stop_test();
  end
endmodule : sdsm_stepper_drive_test
